// file: design/acs_pkg.sv
// Shared constants and types for the calibration sequencer.
package acs_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ACS_OFS_COMMAND   = 8'h00; // Mode, gain, rate.
  localparam logic [7:0] ACS_OFS_OFFSETCAL = 8'h04; // Offset correction.
  localparam logic [7:0] ACS_OFS_FULLCAL   = 8'h08; // Full-scale correction.
  localparam logic [7:0] ACS_OFS_STATUS    = 8'h0C; // Sticky events, W1C.
  localparam logic [7:0] ACS_OFS_MASK      = 8'h10; // Interrupt mask.
  localparam logic [7:0] ACS_OFS_STATE     = 8'h14; // Sequencer state.

  // Command register field positions.
  localparam int ACS_CMD_MODE_LSB  = 0;  // Three-bit operation mode.
  localparam int ACS_CMD_GAIN_LSB  = 4;  // Three-bit gain select code.
  localparam int ACS_CMD_RATE_LSB  = 8;  // Three-bit speed-up rate code.
  localparam int ACS_CMD_SLAVE_BIT = 12; // One when the port is serial slave.

  // Status and mask bit positions.
  localparam int ACS_EVT_CALDONE = 0; // A one-shot calibration finished.
  localparam int ACS_EVT_VALID   = 1; // Valid data was flagged.
  localparam int ACS_EVT_W       = 2; // Number of event bits.

  // Values after reset.
  localparam logic [2:0]  ACS_RST_MODE = 3'h0;
  localparam logic [2:0]  ACS_RST_CODE = 3'h0;
  localparam logic [23:0] ACS_RST_CAL  = 24'h000000;
  localparam logic [23:0] ACS_RST_FULL = 24'h400000;

  // Highest legal code of the gain and rate fields (x1 to x16).
  localparam logic [2:0] ACS_CODE_MAX = 3'h4;

  // Phase lengths in conversion periods.
  localparam logic [2:0] ACS_LEN_CAL   = 3'h3; // Calibration phase.
  localparam logic [2:0] ACS_LEN_SLAVE = 3'h4; // First phase as slave.
  localparam logic [2:0] ACS_LEN_FILL  = 3'h3; // Filter filling.
  localparam logic [2:0] ACS_LEN_ONE   = 3'h1; // Single conversion.

  // Clock cycles that the data-ready output pulses low.
  localparam int ACS_VALID_LOW_CYCLES = 4;

  // Operation mode encodings.
  typedef enum logic [2:0]
  {
    ACS_MODE_NORMAL = 3'b000,
    ACS_MODE_SELF   = 3'b001,
    ACS_MODE_SYSOFF = 3'b010,
    ACS_MODE_SYSFS  = 3'b011,
    ACS_MODE_PSEUDO = 3'b100,
    ACS_MODE_BACKGD = 3'b101,
    ACS_MODE_SLEEP  = 3'b110
  } acs_mode_t;

  // Sequencer states.
  typedef enum logic [2:0]
  {
    ACS_ST_NORMAL = 3'b000,
    ACS_ST_OFFSET = 3'b001,
    ACS_ST_GAIN   = 3'b010,
    ACS_ST_FILL   = 3'b011,
    ACS_ST_SETTLE = 3'b100,
    ACS_ST_BGOUT  = 3'b101,
    ACS_ST_SLEEP  = 3'b110
  } acs_state_t;

endpackage

// file: design/acs_period_counter.sv
`timescale 1ns/1ps
// Counts conversion-period strobes inside one sequencer phase.
module acs_period_counter
#(
  parameter int W = 3 // Counter width.
)
(
  input  wire logic         clk_sys,   // System clock.
  input  wire logic         sys_rst,   // Asynchronous reset, active high.
  input  wire logic         restart,   // Start a new phase from zero.
  input  wire logic         tick,      // One completed conversion period.
  input  wire logic [W-1:0] length,    // Phase length in periods.
  output logic              lastTick   // Tick that closes the phase.
);

  initial
  begin
    if (W < 3)
      $error("acs_period_counter needs at least three bits");
  end

  // All state of this counter.
  typedef struct packed
  {
    logic [W-1:0] count; // Periods completed in this phase.
  } acs_cnt_state_t;

  acs_cnt_state_t cur;     // Registered state.
  acs_cnt_state_t next_cur; // Next state.

  // The closing tick is combinational so the phase ends on that strobe.
  assign lastTick = tick && (cur.count == length - W'(1));

  // Count ticks; a restart wins because a new phase begins with it.
  always_comb
  begin
    next_cur = cur;
    if (restart)
      next_cur.count = '0;
    else if (tick)
      next_cur.count = cur.count + W'(1);
  end

  // Register the state.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

endmodule

// file: design/acs_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - Gain select accepts codes for x1 to x16.
// - Background repeats until changed; others run once.
// - Calibration results land in correction registers.
// - Host reads and overwrites corrections; both used.
// - Mode 001 starts self-calibration, ready held high.
// - Self offset phase shorts inputs, three/four periods.
// - Self gain phase across reference, three periods.
// - Self-calibration end clears mode, reconnects input.
// - Three fill periods, then ready goes low.
// - Mode 010 system offset, three/four periods.
// - System calibrations end with one settling conversion.
// - Mode 011 system full-scale, three/four periods.
// - Full-scale end returns mode to normal itself.
// - Mode 101 interleaves offset, gain until changed.
// - Mode 100 pseudo: live offset, reference gain, fill.
module acs_sequencer
#(
  parameter int CAL_W = 24 // Width of the correction words.
)
(
  input  wire logic                clk_sys,             // 20 MHz clock.
  input  wire logic                sys_rst,             // Async reset.
  input  wire logic                psel,                // APB select.
  input  wire logic                penable,             // APB access.
  input  wire logic                pwrite,              // APB direction.
  input  wire logic [7:0]          paddr,               // APB address.
  input  wire logic [31:0]         pwdata,              // APB write data.
  output logic                     pready,              // APB ready.
  output logic [31:0]              prdata,              // APB read data.
  output logic                     pslverr,             // APB error.
  input  wire logic                periodDone,          // Period strobe.
  input  wire logic [CAL_W-1:0]    offsetMeasured,      // Offset result.
  input  wire logic [CAL_W-1:0]    gainMeasured,        // Gain result.
  output logic                     conversion_valid_n,  // Data ready, low.
  output logic                     inputShorted,        // Inputs shorted.
  output logic                     inputToReference,    // Across reference.
  output logic [2:0]               input_gain_stage,    // Gain code.
  output logic [2:0]               modulator_speedup_rate, // Rate code.
  output logic [CAL_W-1:0]         offsetCorrection,    // Offset in use.
  output logic [CAL_W-1:0]         gainCorrection,      // Gain in use.
  output logic                     irq                  // Interrupt level.
);

  import acs_pkg::*;

  initial
  begin
    if (CAL_W < 1 || CAL_W > 32)
      $error("acs_sequencer supports correction widths 1 to 32");
  end

  // Width of the low-pulse counter on the data-ready output.
  localparam int LOW_W = $clog2(ACS_VALID_LOW_CYCLES + 1);

  // All state of the sequencer and its register file.
  typedef struct packed
  {
    acs_mode_t            mode;      // Operation mode field.
    logic [2:0]           gainCode;  // Gain select field.
    logic [2:0]           rateCode;  // Speed-up rate field.
    logic                 slave;     // Serial slave configuration.
    logic [CAL_W-1:0]     offsetCal; // Offset correction.
    logic [CAL_W-1:0]     fullCal;   // Full-scale correction.
    logic [ACS_EVT_W-1:0] status;    // Sticky events.
    logic [ACS_EVT_W-1:0] mask;      // Interrupt enables.
    acs_state_t           state;     // Sequencer state.
    acs_mode_t            kind;      // Calibration being run.
    logic                 bgGainNext; // Background: gain phase is next.
    logic                 bgFirst;   // Background: first offset phase.
    logic [LOW_W-1:0]     lowCount;  // Cycles of low data-ready left.
    logic [31:0]          rdata;     // Read data captured at setup.
    logic                 err;       // Error captured at setup.
  } acs_state_all_t;

  acs_state_all_t cur;      // Registered state.
  acs_state_all_t next_cur; // Next state.

  logic       phaseRestart; // Start counting a new phase.
  logic [2:0] phaseLength;  // Length of the current phase.
  logic       phaseEnd;     // Strobe that closes the current phase.
  logic       setup;        // APB setup cycle.
  logic       wrAccess;     // APB write taking effect.
  logic       mapped;       // Address hits a register.

  // Period counter shared by every phase.
  acs_period_counter #(.W(3)) u_count
  (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .restart  (phaseRestart),
    .tick     (periodDone),
    .length   (phaseLength),
    .lastTick (phaseEnd)
  );

  // Phase length from state and calibration kind.
  always_comb
  begin
    phaseLength = ACS_LEN_CAL;
    case (cur.state)
      ACS_ST_OFFSET:
      begin
        // Only the first offset phase of background mode is longer.
        if (cur.slave && (cur.kind != ACS_MODE_BACKGD || cur.bgFirst))
          phaseLength = ACS_LEN_SLAVE;
      end
      ACS_ST_GAIN:
      begin
        // Full-scale alone is a first phase; self and pseudo follow offset.
        if (cur.slave && cur.kind == ACS_MODE_SYSFS)
          phaseLength = ACS_LEN_SLAVE;
      end
      ACS_ST_FILL:   phaseLength = ACS_LEN_FILL;
      ACS_ST_SETTLE: phaseLength = ACS_LEN_ONE;
      ACS_ST_BGOUT:  phaseLength = ACS_LEN_ONE;
      default:       phaseLength = ACS_LEN_ONE;
    endcase
  end

  // APB decode; pready is high in every access phase, no wait states.
  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite && !cur.err;
  assign pready   = psel && penable;
  assign prdata   = cur.rdata;
  assign pslverr  = cur.err;
  assign mapped   = (paddr == ACS_OFS_COMMAND)   ||
                    (paddr == ACS_OFS_OFFSETCAL) ||
                    (paddr == ACS_OFS_FULLCAL)   ||
                    (paddr == ACS_OFS_STATUS)    ||
                    (paddr == ACS_OFS_MASK)      ||
                    (paddr == ACS_OFS_STATE);

  // Outputs decoded from state flip-flops alone.
  assign conversion_valid_n     = (cur.lowCount == '0);
  assign input_gain_stage       = cur.gainCode;
  assign modulator_speedup_rate = cur.rateCode;
  assign offsetCorrection       = cur.offsetCal;
  assign gainCorrection         = cur.fullCal;
  assign irq                    = |(cur.status & cur.mask);
  // Switch control follows the phase; the fill phase has the input back.
  assign inputShorted     = (cur.state == ACS_ST_OFFSET) &&
                            (cur.kind == ACS_MODE_SELF ||
                             cur.kind == ACS_MODE_BACKGD);
  assign inputToReference = (cur.state == ACS_ST_GAIN) &&
                            (cur.kind != ACS_MODE_SYSFS);

  // Sequencer, register file and event logic in one next-state process.
  always_comb
  begin
    logic [ACS_EVT_W-1:0] events; // Events raised this cycle.
    logic                 flagValid; // Start a low pulse on data-ready.
    logic                 clearMode; // Hardware returns mode to normal.
    logic                 offLatched; // Offset result latched now.
    logic                 fullLatched; // Gain result latched now.
    events       = '0;
    flagValid    = 1'b0;
    clearMode    = 1'b0;
    offLatched   = 1'b0;
    fullLatched  = 1'b0;
    next_cur     = cur;
    phaseRestart = 1'b0;

    // The low pulse on data-ready runs down on its own.
    if (cur.lowCount != '0)
      next_cur.lowCount = cur.lowCount - LOW_W'(1);

    case (cur.state)
      ACS_ST_NORMAL:
      begin
        // The mode is looked at only on a period strobe.
        if (periodDone)
        begin
          phaseRestart  = 1'b1;
          next_cur.kind = cur.mode;
          case (cur.mode)
            ACS_MODE_SELF, ACS_MODE_SYSOFF, ACS_MODE_PSEUDO:
              next_cur.state = ACS_ST_OFFSET;
            ACS_MODE_SYSFS:
              next_cur.state = ACS_ST_GAIN;
            ACS_MODE_BACKGD:
            begin
              next_cur.state   = ACS_ST_OFFSET;
              next_cur.bgFirst = 1'b1;
            end
            ACS_MODE_SLEEP:
              next_cur.state = ACS_ST_SLEEP;
            default:
              flagValid = 1'b1; // Ordinary conversion finished.
          endcase
        end
      end
      ACS_ST_OFFSET:
      begin
        if (phaseEnd)
        begin
          phaseRestart       = 1'b1;
          next_cur.offsetCal = offsetMeasured;
          offLatched         = 1'b1;
          next_cur.bgFirst   = 1'b0;
          case (cur.kind)
            ACS_MODE_SYSOFF:
            begin
              clearMode      = 1'b1;
              next_cur.state = ACS_ST_SETTLE;
            end
            ACS_MODE_BACKGD:
            begin
              next_cur.bgGainNext = 1'b1;
              next_cur.state      = ACS_ST_FILL;
            end
            default:
              next_cur.state = ACS_ST_GAIN;
          endcase
        end
      end
      ACS_ST_GAIN:
      begin
        if (phaseEnd)
        begin
          phaseRestart     = 1'b1;
          next_cur.fullCal = gainMeasured;
          fullLatched      = 1'b1;
          case (cur.kind)
            ACS_MODE_SYSFS:
            begin
              clearMode      = 1'b1;
              next_cur.state = ACS_ST_SETTLE;
            end
            ACS_MODE_BACKGD:
            begin
              next_cur.bgGainNext = 1'b0;
              next_cur.state      = ACS_ST_FILL;
            end
            default:
            begin
              clearMode      = 1'b1;
              next_cur.state = ACS_ST_FILL;
            end
          endcase
        end
      end
      ACS_ST_FILL:
      begin
        // Filter refill with data-ready still high.
        if (phaseEnd)
        begin
          phaseRestart = 1'b1;
          flagValid    = 1'b1;
          if (cur.kind == ACS_MODE_BACKGD)
            next_cur.state = ACS_ST_BGOUT;
          else
          begin
            events[ACS_EVT_CALDONE] = 1'b1;
            next_cur.state          = ACS_ST_NORMAL;
          end
        end
      end
      ACS_ST_SETTLE:
      begin
        // One conversion with data-ready high, then normal.
        if (phaseEnd)
        begin
          phaseRestart            = 1'b1;
          flagValid               = 1'b1;
          events[ACS_EVT_CALDONE] = 1'b1;
          next_cur.state          = ACS_ST_NORMAL;
        end
      end
      ACS_ST_BGOUT:
      begin
        // Background keeps going until another mode is written.
        if (phaseEnd)
        begin
          phaseRestart = 1'b1;
          if (cur.mode != ACS_MODE_BACKGD)
            next_cur.state = ACS_ST_NORMAL;
          else if (cur.bgGainNext)
            next_cur.state = ACS_ST_GAIN;
          else
            next_cur.state = ACS_ST_OFFSET;
        end
      end
      ACS_ST_SLEEP:
      begin
        // Leave sleep at the first boundary after a new mode.
        if (periodDone && cur.mode != ACS_MODE_SLEEP)
          next_cur.state = ACS_ST_NORMAL;
      end
      default:
        next_cur.state = ACS_ST_NORMAL;
    endcase

    if (flagValid)
    begin
      next_cur.lowCount     = LOW_W'(ACS_VALID_LOW_CYCLES);
      events[ACS_EVT_VALID] = 1'b1;
    end
    if (clearMode)
      next_cur.mode = ACS_MODE_NORMAL;

    // Read data and error are captured in the setup cycle.
    if (setup)
    begin
      next_cur.err   = !mapped;
      next_cur.rdata = 32'h00000000;
      case (paddr)
        ACS_OFS_COMMAND:
        begin
          next_cur.rdata[ACS_CMD_MODE_LSB +: 3] = cur.mode;
          next_cur.rdata[ACS_CMD_GAIN_LSB +: 3] = cur.gainCode;
          next_cur.rdata[ACS_CMD_RATE_LSB +: 3] = cur.rateCode;
          next_cur.rdata[ACS_CMD_SLAVE_BIT]     = cur.slave;
        end
        ACS_OFS_OFFSETCAL: next_cur.rdata[CAL_W-1:0] = cur.offsetCal;
        ACS_OFS_FULLCAL:   next_cur.rdata[CAL_W-1:0] = cur.fullCal;
        ACS_OFS_STATUS:    next_cur.rdata[ACS_EVT_W-1:0] = cur.status;
        ACS_OFS_MASK:      next_cur.rdata[ACS_EVT_W-1:0] = cur.mask;
        ACS_OFS_STATE:     next_cur.rdata[2:0] = cur.state;
        default:           next_cur.rdata = 32'h00000000;
      endcase
    end

    // Register writes take effect at the access edge.
    if (wrAccess)
    begin
      case (paddr)
        ACS_OFS_COMMAND:
        begin
          // A host write of the mode wins over the hardware clear.
          next_cur.mode  = acs_mode_t'(pwdata[ACS_CMD_MODE_LSB +: 3]);
          next_cur.slave = pwdata[ACS_CMD_SLAVE_BIT];
          // Codes beyond x16 are refused and the old code stays.
          if (pwdata[ACS_CMD_GAIN_LSB +: 3] <= ACS_CODE_MAX)
            next_cur.gainCode = pwdata[ACS_CMD_GAIN_LSB +: 3];
          if (pwdata[ACS_CMD_RATE_LSB +: 3] <= ACS_CODE_MAX)
            next_cur.rateCode = pwdata[ACS_CMD_RATE_LSB +: 3];
        end
        // A result latched in the same cycle beats a host write.
        ACS_OFS_OFFSETCAL:
        begin
          if (!offLatched)
            next_cur.offsetCal = pwdata[CAL_W-1:0];
        end
        ACS_OFS_FULLCAL:
        begin
          if (!fullLatched)
            next_cur.fullCal = pwdata[CAL_W-1:0];
        end
        ACS_OFS_STATUS:
          next_cur.status = cur.status & ~pwdata[ACS_EVT_W-1:0];
        ACS_OFS_MASK:
          next_cur.mask = pwdata[ACS_EVT_W-1:0];
        default:
          next_cur.mask = cur.mask;
      endcase
    end

    // New events are set after the clear so that setting wins.
    next_cur.status = next_cur.status | events;
  end

  // Register the whole state; reset gives constants only.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur            <= '0;
      cur.mode       <= acs_mode_t'(ACS_RST_MODE);
      cur.gainCode   <= ACS_RST_CODE;
      cur.rateCode   <= ACS_RST_CODE;
      cur.offsetCal  <= CAL_W'(ACS_RST_CAL);
      cur.fullCal    <= CAL_W'(ACS_RST_FULL);
      cur.state      <= ACS_ST_NORMAL;
      cur.kind       <= ACS_MODE_NORMAL;
    end
    else
      cur <= next_cur;
  end

endmodule

// file: bench/acs_sequencer_props.sv
`timescale 1ns/1ps
// Port-level timing checks for the calibration sequencer.
module acs_sequencer_props
#(
  parameter int CAL_W = 24 // Correction width.
)
(
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic             pready,
  input wire logic             periodDone,
  input wire logic             conversion_valid_n,
  input wire logic             inputShorted,
  input wire logic             inputToReference,
  input wire logic [2:0]       input_gain_stage,
  input wire logic [CAL_W-1:0] offsetCorrection
);
  import acs_pkg::*;
  // A host write of the offset word, the only other cause of a change.
  logic wrOff;
  assign wrOff = psel && penable && pwrite && (paddr == ACS_OFS_OFFSETCAL);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("ready missing in access phase");
  property p_short; inputShorted |-> conversion_valid_n; endproperty
  a_short: assert property (p_short)
    else $error("ready low while inputs shorted");
  property p_ref; inputToReference |-> conversion_valid_n && !inputShorted;
  endproperty
  a_ref: assert property (p_ref)
    else $error("bad state during reference phase");
  // Four low cycles, then high again; a stuck count shows here.
  property p_lowlen;
    $fell(conversion_valid_n) |-> !conversion_valid_n [*4] ##1
      conversion_valid_n;
  endproperty
  a_lowlen: assert property (p_lowlen)
    else $error("valid pulse length wrong");
  property p_lowcause; $fell(conversion_valid_n) |-> $past(periodDone);
  endproperty
  a_lowcause: assert property (p_lowcause)
    else $error("valid pulse without period strobe");
  property p_edge; $rose(inputShorted) |-> $past(periodDone); endproperty
  a_edge: assert property (p_edge)
    else $error("calibration began off a period boundary");
  property p_gain; input_gain_stage <= ACS_CODE_MAX; endproperty
  a_gain: assert property (p_gain)
    else $error("gain code out of range");
  property p_corr;
    $changed(offsetCorrection) |-> $past(periodDone) || $past(wrOff);
  endproperty
  a_corr: assert property (p_corr)
    else $error("offset correction changed without cause");
  c_short: cover property ($rose(inputShorted));
  c_ref: cover property ($rose(inputToReference));
  c_valid: cover property ($fell(conversion_valid_n));
endmodule
bind acs_sequencer acs_sequencer_props #(.CAL_W(CAL_W)) u_props
(
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .periodDone(periodDone), .conversion_valid_n(conversion_valid_n),
  .inputShorted(inputShorted), .inputToReference(inputToReference),
  .input_gain_stage(input_gain_stage), .offsetCorrection(offsetCorrection)
);

// file: bench/acs_modulator_model.sv
`timescale 1ns/1ps
// Decimation filter stand-in: one strobe per conversion period.
module acs_modulator_model
#(
  parameter int PERIOD = 12 // Clocks per period; long enough for a pulse.
)
(
  input  wire logic        clk_sys,        // System clock.
  input  wire logic        sys_rst,        // Async reset.
  input  wire logic [23:0] offVal,         // Offset the next run measures.
  input  wire logic [23:0] gainVal,        // Gain the next run measures.
  output logic             periodDone,     // Period strobe.
  output logic [23:0]      offsetMeasured, // Offset result.
  output logic [23:0]      gainMeasured    // Gain result.
);
  int cnt; // Position within the period.
  // Results follow the bench so each run has a fresh expectation.
  assign offsetMeasured = offVal;
  assign gainMeasured   = gainVal;
  // One single-cycle strobe closes every period.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt        <= 0;
      periodDone <= 1'b0;
    end
    else
    begin
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      periodDone <= (cnt == PERIOD - 1);
    end
  end
endmodule

// file: bench/acs_sequencer_bench.sv
`timescale 1ns/1ps
// Drives the sequencer over the register bus and checks it.
module acs_sequencer_bench;
  import acs_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        pready, pslverr, periodDone, conversion_valid_n, irq;
  logic        inputShorted, inputToReference;
  logic [2:0]  input_gain_stage, modulator_speedup_rate;
  logic [23:0] offVal, gainVal, offM, gainM, offC, gainC, expOff, expGain;
  logic [32:0] expQ[$]; // Expected {error, data} of each read.
  int          err_count, tests_run, n;
  acs_sequencer dut
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .periodDone(periodDone),
    .offsetMeasured(offM), .gainMeasured(gainM),
    .conversion_valid_n(conversion_valid_n), .inputShorted(inputShorted),
    .inputToReference(inputToReference),
    .input_gain_stage(input_gain_stage),
    .modulator_speedup_rate(modulator_speedup_rate),
    .offsetCorrection(offC), .gainCorrection(gainC), .irq(irq)
  );
  acs_modulator_model mdl
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .offVal(offVal),
    .gainVal(gainVal), .periodDone(periodDone), .offsetMeasured(offM),
    .gainMeasured(gainM)
  );
  // Clock at 20 MHz.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      check(33'h0, 33'h1);
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Reads are judged here, at the edge that completes them.
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, expQ.pop_front());
  // Counts strobes until the next valid pulse; a hang ends the run.
  task automatic count_valid(output int c);
    int k;
    logic hi;
    c = 0;
    hi = 1'b0;
    for (k = 0; k < 600; k++)
    begin
      @(posedge clk_sys);
      if (periodDone)
        c++;
      if (conversion_valid_n === 1'b1)
        hi = 1'b1;
      else if (hi)
        break;
    end
    if (k >= 600)
    begin
      check(33'h0, 33'h1);
      finish_test();
    end
  endtask
  // Starts a run just after a normal pulse so the strobe count is exact.
  task automatic cal(input logic [2:0] m, input logic s, input int exp);
    count_valid(n);
    repeat (5) @(posedge clk_sys);
    seed = xs(seed);
    offVal <= seed[23:0];
    gainVal <= seed[31:8];
    expOff  = (m == 3'h3) ? expOff : seed[23:0];
    expGain = (m == 3'h2) ? expGain : seed[31:8];
    apb(1'b1, ACS_OFS_COMMAND, {19'h0, s, 9'h088, m});
    count_valid(n);
    check(n, exp);
    rd(ACS_OFS_COMMAND, {20'h0, s, 12'h440});
    check(offC, expOff);
    check(gainC, expGain);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, tests_run} = '0;
    seed = 32'ha1835d52;
    offVal = 24'h0;
    gainVal = 24'h0;
    expOff = ACS_RST_CAL;
    expGain = ACS_RST_FULL;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(ACS_OFS_FULLCAL, {9'h0, ACS_RST_FULL});
    rd(ACS_OFS_STATE, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    // Every legal gain and rate code, then an illegal one that is kept out.
    for (int g = 0; g < 5; g++)
    begin
      apb(1'b1, ACS_OFS_COMMAND, {21'h0, 3'(g), 1'b0, 3'(g), 4'h0});
      check({input_gain_stage, modulator_speedup_rate}, {3'(g), 3'(g)});
    end
    apb(1'b1, ACS_OFS_COMMAND, 32'h0000_0550);
    rd(ACS_OFS_COMMAND, 33'h0000_0440);
    apb(1'b1, ACS_OFS_MASK, 32'h1);
    cal(ACS_MODE_SELF, 1'b0, 10);
    check(irq, 1'b1);
    rd(ACS_OFS_STATUS, 33'h3);
    apb(1'b1, ACS_OFS_STATUS, 32'h3);
    check(irq, 1'b0);
    cal(ACS_MODE_SELF, 1'b1, 11);
    // System offset strictly before system full-scale.
    cal(ACS_MODE_SYSOFF, 1'b1, 6);
    cal(ACS_MODE_SYSFS, 1'b0, 5);
    cal(ACS_MODE_PSEUDO, 1'b0, 10);
    // Host overwrites the corrections, as after averaging.
    seed = xs(seed);
    apb(1'b1, ACS_OFS_OFFSETCAL, {8'h0, seed[23:0]});
    apb(1'b1, ACS_OFS_FULLCAL, {8'h0, seed[31:8]});
    check(offC, seed[23:0]);
    check(gainC, seed[31:8]);
    rd(ACS_OFS_OFFSETCAL, {9'h0, seed[23:0]});
    // Background runs twice round; the host then leaves it.
    count_valid(n);
    apb(1'b1, ACS_OFS_COMMAND, {29'h0, ACS_MODE_BACKGD});
    count_valid(n);
    check(n, 7);
    count_valid(n);
    check(n, 7);
    apb(1'b1, ACS_OFS_COMMAND, 32'h0);
    count_valid(n);
    count_valid(n);
    check(n, 1);
    finish_test();
  end
endmodule
